//--- hw/acr_regs.sv
// acr_regs: register bank, test patterns and output scrambler of a
// four-core adc; one core_clk domain, registers written by a serial front end.
// assumes wr_en/rd_en pulses on core_clk; sync_pulse is an asynchronous pin.
`timescale 1ns/100ps
// Contract
// - standby bit 1 powers core down; the code takes the standby bit from wr_data[0]
// - simultaneous mode with any core mix
// - single-core standby write affects that core only
// - select code 4 writes all cores
// - select code 7 routes to master set
// - select codes 0..3 pick cores A..D
// - swing control resets zero, reduced swing
// - source bit 2 picks spi resistance
// - bit 1 common mode, bit 0 offset
// - unselected settings fall back to otp
// - resistance code 1C, readback 70
// - common mode code 1B, readback 6F
// - test enable bit 0, mode above
// - ramp mode outputs 12-bit ramp
// - flash length field resets to 18h
// - flash lasts four times field plus one
// - one prbs bit xors all outputs
// - prbs advances every N cycles
// - scramble control enable and suppress bits
// - sync restarts all prbs generators
// - master holds fixed identification code
// - checksum status bits and otp ready
// - otp ready rises within 1 ms
module acr_regs #(
	parameter int          OTP_READY_CYCLES = acr_pkg::OTP_READY_CYCLES,
	parameter logic [11:0] PART_ID          = 12'h5a5 // arbitrary value
) (
	input  wire logic        core_clk,
	input  wire logic        rst_b,
	input  wire logic        wr_en,
	input  wire logic        rd_en,
	input  wire logic [6:0]  addr,
	input  wire logic [15:0] wr_data,
	output logic      [15:0] rd_data,
	input  wire logic        sync_pulse,
	input  wire logic [55:0] conv_data,
	input  wire logic [3:0]  conv_in_range,
	input  wire logic [4:0]  otp_checksum_ok,
	input  wire logic [4:0]  otp_cm_value,
	input  wire logic [3:0]  otp_rin_value,
	output logic      [3:0]  core_power_down,
	output logic             full_swing,
	output logic      [4:0]  input_common_mode_code_use,
	output logic      [3:0]  rin_in_use,
	output logic             offset_from_spi,
	output logic      [55:0] out_data,
	output logic      [3:0]  out_parity,
	output logic      [3:0]  out_in_range
);
	// ****************************************************************
	// shared state
	// ****************************************************************
	logic [2:0]  set_sel_q;
	logic [2:0]  src_sel_q;
	logic [4:0]  cm_code_q;
	logic [3:0]  rin_code_q;
	logic        swing_q;
	logic [3:0]  pd_q;
	logic [6:0]  test_ctrl_q [4];
	logic [5:0]  flash_len_q [4];
	logic [1:0]  scr_ctrl_q  [4];
	logic [4:0]  scr_per_q   [4];
	logic [6:0]  lfsr_q      [4];
	logic [4:0]  scr_cnt_q   [4];
	logic [8:0]  flash_cnt_q [4];
	logic [11:0] ramp_q      [4];
	logic [19:0] otp_cnt_q;
	logic        otp_ready_q;
	logic [1:0]  sync_meta_q;
	logic        sync_prev_q;
	logic [4:0]  ok_s1_q;
	logic [4:0]  ok_s2_q;
	logic [15:0] rd_data_q;

	function automatic logic [6:0] lfsr_step(input logic [6:0] s);
		lfsr_step = {s[5:0], s[6] ^ s[5]}; // x^7 + x^6 + 1
	endfunction

	// ****************************************************************
	// decode
	// ****************************************************************
	wire       master_sel = set_sel_q == acr_pkg::SEL_MASTER;
	wire       all_sel    = set_sel_q == acr_pkg::SEL_ALL;
	wire       core_sel   = set_sel_q <= acr_pkg::SEL_CORE_D;
	wire [1:0] core_idx   = set_sel_q[1:0];
	wire       sync_rise  = sync_meta_q[1] & ~sync_prev_q;
	wire       wr_sel     = wr_en && addr == acr_pkg::A_SET_SELECT;
	wire       wr_master  = wr_en && master_sel;
	logic [3:0] core_wr;
	always_comb
	begin
		for (int c = 0; c < 4; c++)
			core_wr[c] = wr_en && (all_sel || (core_sel && core_idx == 2'(c)));
	end

	// ****************************************************************
	// master set and select register
	// ****************************************************************
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			set_sel_q  <= acr_pkg::SEL_MASTER;
			src_sel_q  <= '0;
			cm_code_q  <= acr_pkg::CM_RESET;
			rin_code_q <= acr_pkg::RIN_RESET;
			swing_q    <= 1'b0;
		end
		else
		begin
			if (wr_sel)
				set_sel_q <= wr_data[2:0];
			if (wr_master && addr == acr_pkg::A_SRC_SELECT)
				src_sel_q <= wr_data[2:0];
			if (wr_master && addr == acr_pkg::A_CM_CODE)
				cm_code_q <= wr_data[4:0];
			if (wr_master && addr == acr_pkg::A_RIN_CODE)
				rin_code_q <= wr_data[3:0];
			if (wr_master && addr == acr_pkg::A_SWING)
				swing_q <= wr_data[0];
		end
	end

	// values in use follow the select bit each cycle, so unselected ones are otp
	wire [4:0] cm_use  = src_sel_q[acr_pkg::SRC_CM_BIT]  ? cm_code_q  : otp_cm_value;
	wire [3:0] rin_use = src_sel_q[acr_pkg::SRC_RIN_BIT] ? rin_code_q : otp_rin_value;

	// ****************************************************************
	// per-core sets
	// ****************************************************************
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			pd_q <= '0;
			for (int c = 0; c < 4; c++)
			begin
				test_ctrl_q[c] <= '0;
				flash_len_q[c] <= acr_pkg::FLASH_RESET;
				scr_ctrl_q[c]  <= '0;
				scr_per_q[c]   <= acr_pkg::PERIOD_RESET;
			end
		end
		else
		begin
			for (int c = 0; c < 4; c++)
			begin
				if (core_wr[c] && addr == acr_pkg::A_POWER_DOWN)
					pd_q[c] <= wr_data[0];
				if (core_wr[c] && addr == acr_pkg::A_TEST_CTRL)
					test_ctrl_q[c] <= wr_data[6:0];
				if (core_wr[c] && addr == acr_pkg::A_FLASH_LEN)
					flash_len_q[c] <= wr_data[5:0];
				if (core_wr[c] && addr == acr_pkg::A_SCRAMBLE)
					scr_ctrl_q[c] <= wr_data[1:0];
				if (core_wr[c] && addr == acr_pkg::A_SCR_PERIOD && wr_data[4:0] != 5'h00)
					scr_per_q[c] <= wr_data[4:0];
			end
		end
	end

	// ****************************************************************
	// sync pin and otp status inputs
	// ****************************************************************
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			sync_meta_q <= '0;
			sync_prev_q <= 1'b0;
			ok_s1_q     <= '0;
			ok_s2_q     <= '0;
			otp_cnt_q   <= '0;
			otp_ready_q <= 1'b0;
		end
		else
		begin
			sync_meta_q <= {sync_meta_q[0], sync_pulse};
			sync_prev_q <= sync_meta_q[1];
			ok_s1_q     <= otp_checksum_ok;
			ok_s2_q     <= ok_s1_q;
			// fixed wake-up count stands in for the fuse settling time
			if (!otp_ready_q)
				otp_cnt_q <= otp_cnt_q + 20'h00001;
			if (otp_cnt_q == 20'(OTP_READY_CYCLES))
				otp_ready_q <= 1'b1;
		end
	end

	// ****************************************************************
	// pattern generators and scrambler
	// ****************************************************************
	acr_pkg::acr_pat_t pat [4];
	logic [8:0]  flash_len_cyc [4];
	always_comb
	begin
		for (int c = 0; c < 4; c++)
		begin
			flash_len_cyc[c] = {1'b0, flash_len_q[c] + 6'h01, 2'b00};
			if (!test_ctrl_q[c][0])
				pat[c] = acr_pkg::ACR_PAT_NORMAL;
			else if (test_ctrl_q[c][6:1] == acr_pkg::MODE_FLASH)
				pat[c] = acr_pkg::ACR_PAT_FLASH;
			else if (test_ctrl_q[c][6:1] == acr_pkg::MODE_RAMP)
				pat[c] = acr_pkg::ACR_PAT_RAMP;
			else
				pat[c] = acr_pkg::ACR_PAT_NORMAL;
		end
	end
	// 3f gives 256: 6-bit sum wraps, so the 64 case is patched below
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			for (int c = 0; c < 4; c++)
			begin
				lfsr_q[c]      <= acr_pkg::PRBS_SEED;
				scr_cnt_q[c]   <= '0;
				flash_cnt_q[c] <= '0;
				ramp_q[c]      <= '0;
			end
		end
		else
		begin
			for (int c = 0; c < 4; c++)
			begin
				if (sync_rise)
				begin
					lfsr_q[c]      <= acr_pkg::PRBS_SEED;
					scr_cnt_q[c]   <= '0;
					flash_cnt_q[c] <= '0;
					ramp_q[c]      <= '0;
				end
				else
				begin
					ramp_q[c] <= ramp_q[c] + 12'h001;
					if (flash_cnt_q[c] >= ((flash_len_q[c] == 6'h3f) ? 9'h0ff :
						flash_len_cyc[c] - 9'h001))
						flash_cnt_q[c] <= '0;
					else
						flash_cnt_q[c] <= flash_cnt_q[c] + 9'h001;
					if (scr_cnt_q[c] >= scr_per_q[c] - 5'h01)
					begin
						scr_cnt_q[c] <= '0;
						lfsr_q[c]    <= lfsr_step(lfsr_q[c]);
					end
					else
						scr_cnt_q[c] <= scr_cnt_q[c] + 5'h01;
				end
			end
		end
	end

	logic [13:0] word [4];
	logic [13:0] word_x [4];
	always_comb
	begin
		for (int c = 0; c < 4; c++)
		begin
			case (pat[c])
				acr_pkg::ACR_PAT_FLASH:
					word[c] = {flash_cnt_q[c] == 9'h000 ? 12'hfff : 12'h000, 2'b01};
				acr_pkg::ACR_PAT_RAMP:
					word[c] = {ramp_q[c], ^ramp_q[c], 1'b1};
				acr_pkg::ACR_PAT_NORMAL:
					word[c] = {conv_data[c*14 +: 12], ^conv_data[c*14 +: 12], conv_in_range[c]};
				default:
					word[c] = '0;
			endcase
			if (scr_ctrl_q[c][1])
				word[c] = '0;
			word_x[c] = word[c] ^ {14{scr_ctrl_q[c][0] & lfsr_q[c][0]}};
		end
	end

	// ****************************************************************
	// read mux
	// ****************************************************************
	logic [15:0] rd_mux;
	always_comb
	begin
		rd_mux = '0;
		if (addr == acr_pkg::A_SET_SELECT)
			rd_mux = {13'h0000, set_sel_q};
		else if (master_sel)
			case (addr)
				acr_pkg::A_CHECKSUM_STAT:
					rd_mux = {8'h00, ok_s2_q, 2'b00, otp_ready_q};
				acr_pkg::A_PART_ID:     rd_mux = {4'h0, PART_ID};
				acr_pkg::A_SRC_SELECT:  rd_mux = {13'h0000, src_sel_q};
				acr_pkg::A_CM_CODE:     rd_mux = {11'h000, cm_code_q};
				acr_pkg::A_RIN_CODE:    rd_mux = {12'h000, rin_code_q};
				acr_pkg::A_SWING:       rd_mux = {15'h0000, swing_q};
				acr_pkg::A_CM_READBACK: rd_mux = {11'h000, cm_use};
				acr_pkg::A_RIN_READBACK: rd_mux = {12'h000, rin_use};
				default:                rd_mux = '0;
			endcase
		else
			case (addr)
				acr_pkg::A_POWER_DOWN: rd_mux = {15'h0000, pd_q[core_idx]};
				acr_pkg::A_TEST_CTRL:  rd_mux = {9'h000, test_ctrl_q[core_idx]};
				acr_pkg::A_FLASH_LEN:  rd_mux = {10'h000, flash_len_q[core_idx]};
				acr_pkg::A_SCRAMBLE:   rd_mux = {14'h0000, scr_ctrl_q[core_idx]};
				acr_pkg::A_SCR_PERIOD: rd_mux = {11'h000, scr_per_q[core_idx]};
				acr_pkg::A_OTP_READY:  rd_mux = {15'h0000, otp_ready_q};
				default:               rd_mux = '0;
			endcase
	end

	// ****************************************************************
	// registered outputs
	// ****************************************************************
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			rd_data_q       <= '0;
			core_power_down <= '0;
			full_swing      <= 1'b0;
			input_common_mode_code_use       <= acr_pkg::CM_RESET;
			rin_in_use      <= acr_pkg::RIN_RESET;
			offset_from_spi <= 1'b0;
			out_data        <= '0;
			out_parity      <= '0;
			out_in_range    <= '0;
		end
		else
		begin
			if (rd_en)
				rd_data_q <= rd_mux;
			core_power_down <= pd_q;
			full_swing      <= swing_q;
			input_common_mode_code_use       <= cm_use;
			rin_in_use      <= rin_use;
			offset_from_spi <= src_sel_q[acr_pkg::SRC_OFFSET_BIT];
			for (int c = 0; c < 4; c++)
			begin
				out_data[c*14 +: 14] <= {2'b00, word_x[c][13:2]};
				out_parity[c]        <= word_x[c][1];
				out_in_range[c]      <= word_x[c][0];
			end
		end
	end
	assign rd_data = rd_data_q;

	// ****************************************************************
	// checks
	// ****************************************************************
	property p_pd_follows;
		@(posedge core_clk) disable iff (!rst_b)
		(core_wr[3] && addr == acr_pkg::A_POWER_DOWN && !all_sel) |=>
			pd_q[2:0] == $past(pd_q[2:0]);
	endproperty
	a_pd_follows: assert property (p_pd_follows) else $error("other core standby changed");
	property p_all_write;
		@(posedge core_clk) disable iff (!rst_b)
		(wr_en && all_sel && addr == acr_pkg::A_POWER_DOWN) |=> pd_q == {4{$past(wr_data[0])}};
	endproperty
	a_all_write: assert property (p_all_write) else $error("all-core write missed a core");
	property p_master_iso;
		@(posedge core_clk) disable iff (!rst_b)
		(wr_en && master_sel && addr == acr_pkg::A_SCRAMBLE) |=> $stable(scr_ctrl_q[0]);
	endproperty
	a_master_iso: assert property (p_master_iso) else $error("master write hit a core");
	property p_swing;
		@(posedge core_clk) disable iff (!rst_b)
		(wr_master && addr == acr_pkg::A_SWING) ##1 !(wr_master && addr == acr_pkg::A_SWING)
			|=> full_swing == $past(wr_data[0], 2);
	endproperty
	a_swing: assert property (p_swing) else $error("swing output wrong");
	property p_rin_src;
		@(posedge core_clk) disable iff (!rst_b)
		!src_sel_q[acr_pkg::SRC_RIN_BIT] |=> rin_in_use == $past(otp_rin_value);
	endproperty
	a_rin_src: assert property (p_rin_src) else $error("resistance not from otp");
	property p_cm_src;
		@(posedge core_clk) disable iff (!rst_b)
		src_sel_q[acr_pkg::SRC_CM_BIT] |=> input_common_mode_code_use == $past(cm_code_q);
	endproperty
	a_cm_src: assert property (p_cm_src) else $error("common mode not from spi");
	property p_ramp;
		@(posedge core_clk) disable iff (!rst_b)
		(pat[0] == acr_pkg::ACR_PAT_RAMP && scr_ctrl_q[0] == 2'b00 && !sync_rise)[*2]
			|=> out_data[11:0] == $past(out_data[11:0]) + 12'h001;
	endproperty
	a_ramp: assert property (p_ramp) else $error("ramp did not step");
	property p_reserved;
		@(posedge core_clk) disable iff (!rst_b)
		(test_ctrl_q[0][0] && test_ctrl_q[0][6:1] != acr_pkg::MODE_FLASH &&
			test_ctrl_q[0][6:1] != acr_pkg::MODE_RAMP && scr_ctrl_q[0] == 2'b00)
			|=> out_data[11:0] == $past(conv_data[11:0]);
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved code produced pattern");
	property p_sync;
		@(posedge core_clk) disable iff (!rst_b)
		sync_rise |=> lfsr_q[0] == acr_pkg::PRBS_SEED && lfsr_q[1] == acr_pkg::PRBS_SEED &&
			lfsr_q[2] == acr_pkg::PRBS_SEED && lfsr_q[3] == acr_pkg::PRBS_SEED;
	endproperty
	a_sync: assert property (p_sync) else $error("prbs not aligned after sync");
	property p_otp;
		@(posedge core_clk) disable iff (!rst_b) otp_cnt_q <= 20'(OTP_READY_CYCLES) + 20'h00001;
	endproperty
	a_otp: assert property (p_otp) else $error("otp ready late");
	c_ramp: cover property (@(posedge core_clk) disable iff (!rst_b) pat[0] == acr_pkg::ACR_PAT_RAMP);
	c_flash: cover property (@(posedge core_clk) disable iff (!rst_b) pat[2] == acr_pkg::ACR_PAT_FLASH);
	c_scr: cover property (@(posedge core_clk) disable iff (!rst_b) scr_ctrl_q[1] == 2'b01);
endmodule

//--- hw/acr_pkg.sv
// acr_pkg: addresses, field positions, reset values and timing for the
// adc configuration and test pattern register bank.
// assumes a 7-bit register address and 16-bit data words from the serial port.
package acr_pkg;
	// ****************************************************************
	// addresses
	// ****************************************************************
	localparam logic [6:0] A_SET_SELECT    = 7'h01;
	localparam logic [6:0] A_CHECKSUM_STAT = 7'h05;
	localparam logic [6:0] A_PART_ID       = 7'h06;
	localparam logic [6:0] A_SRC_SELECT    = 7'h16;
	localparam logic [6:0] A_CM_CODE       = 7'h1b;
	localparam logic [6:0] A_RIN_CODE      = 7'h1c;
	localparam logic [6:0] A_SCRAMBLE      = 7'h55;
	localparam logic [6:0] A_OTP_READY     = 7'h5a;
	localparam logic [6:0] A_POWER_DOWN    = 7'h5c;
	localparam logic [6:0] A_TEST_CTRL     = 7'h5d;
	localparam logic [6:0] A_SCR_PERIOD    = 7'h5e;
	localparam logic [6:0] A_FLASH_LEN     = 7'h69;
	localparam logic [6:0] A_SWING         = 7'h6a;
	localparam logic [6:0] A_CM_READBACK   = 7'h6f;
	localparam logic [6:0] A_RIN_READBACK  = 7'h70;
	// ****************************************************************
	// set select codes
	// ****************************************************************
	localparam logic [2:0] SEL_CORE_D = 3'h3;
	localparam logic [2:0] SEL_ALL    = 3'h4;
	localparam logic [2:0] SEL_MASTER = 3'h7;
	// ****************************************************************
	// fields and reset values
	// ****************************************************************
	localparam int         SRC_OFFSET_BIT = 0;
	localparam int         SRC_CM_BIT     = 1;
	localparam int         SRC_RIN_BIT    = 2;
	localparam logic [4:0] CM_RESET       = 5'h10;
	localparam logic [3:0] RIN_RESET      = 4'h8;
	localparam logic [5:0] FLASH_RESET    = 6'h18;
	localparam logic [4:0] PERIOD_RESET   = 5'h01;
	localparam logic [5:0] MODE_FLASH     = 6'h06;
	localparam logic [5:0] MODE_RAMP      = 6'h04;
	localparam logic [6:0] PRBS_SEED      = 7'h7f;
	// ****************************************************************
	// timing: otp ready within 1 ms at 200 MHz
	// ****************************************************************
	localparam real CLK_PERIOD_NS    = 5.0;
	localparam real OTP_READY_MAX_MS = 1.0;
	localparam int  OTP_READY_CYCLES = int'(OTP_READY_MAX_MS * 1.0e6 / CLK_PERIOD_NS) - 1;
	typedef enum logic [1:0] {ACR_PAT_NORMAL, ACR_PAT_FLASH, ACR_PAT_RAMP} acr_pat_t;
endpackage

//--- dv/acr_far_end.sv
// acr_far_end: converter lanes, factory otp values and the lvds capture
// stage that face acr_regs. assumes one core_clk domain shared with the bench.
`timescale 1ns/100ps
module acr_far_end #(
	parameter logic [4:0] CM_OTP  = 5'h0a,
	parameter logic [3:0] RIN_OTP = 4'h3,
	parameter logic [4:0] CK_OK   = 5'h16
) (
	input  wire logic        core_clk,
	input  wire logic [55:0] out_data,
	output logic      [55:0] conv_data,
	output logic      [3:0]  conv_in_range,
	output logic      [4:0]  otp_checksum_ok,
	output logic      [4:0]  otp_cm_value,
	output logic      [3:0]  otp_rin_value,
	output logic      [55:0] captured
);
	// ****************************************************************
	// converter and fuse side
	// ****************************************************************
	// fixed samples keep the normal path predictable; bits 13:12 stay clear
	assign conv_data       = {14'h0abc, 14'h0789, 14'h0456, 14'h0123};
	assign conv_in_range   = 4'hf;
	assign otp_checksum_ok = CK_OK;
	assign otp_cm_value    = CM_OTP;
	assign otp_rin_value   = RIN_OTP;
	// ****************************************************************
	// receiver capture, one word per clock
	// ****************************************************************
	always_ff @(posedge core_clk)
	begin
		captured <= out_data;
	end
endmodule

//--- dv/test_adc_config_and_test_pattern_regs.sv
// test_adc_config_and_test_pattern_regs: self-checking bench for acr_regs.
// assumes acr_pkg, acr_regs and the far-end model acr_far_end.
`timescale 1ns/100ps
module test_adc_config_and_test_pattern_regs;
	typedef struct packed {logic [1:0] op; logic [6:0] a; logic [15:0] d;} acr_row_t;
	localparam logic [11:0] ID = 12'h3c7; // arbitrary value
	logic        core_clk, rst_b, wr_en, rd_en, sync_pulse;
	logic [6:0]  addr;
	logic [15:0] wr_data, rd_data;
	logic [55:0] conv_data, out_data, cap;
	logic [3:0]  conv_in_range, core_power_down, rin_in_use, out_parity, out_in_range;
	logic [3:0]  otp_rin_value;
	logic [4:0]  otp_checksum_ok, otp_cm_value, input_common_mode_code_use;
	logic        full_swing, offset_from_spi, b;
	int          fail_count, num_checks, ones, n;
	logic [15:0] s1, s2;
	// op 0 write, 1 read and compare, 2 compare standby outputs
	localparam acr_row_t rows [33] = '{
		'{2'h1, 7'h06, {4'h0, ID}}, '{2'h1, 7'h6a, 16'h0000}, '{2'h1, 7'h16, 16'h0000},
		'{2'h1, 7'h1b, 16'h0010}, '{2'h1, 7'h1c, 16'h0008}, '{2'h1, 7'h6f, 16'h000a},
		'{2'h1, 7'h70, 16'h0003}, '{2'h0, 7'h6a, 16'h0001}, '{2'h1, 7'h6a, 16'h0001},
		'{2'h0, 7'h16, 16'h0004}, '{2'h1, 7'h70, 16'h0008}, '{2'h1, 7'h6f, 16'h000a},
		'{2'h0, 7'h1c, 16'h0005}, '{2'h1, 7'h70, 16'h0005}, '{2'h0, 7'h1b, 16'h001f},
		'{2'h0, 7'h16, 16'h0002}, '{2'h1, 7'h70, 16'h0003}, '{2'h1, 7'h6f, 16'h001f},
		'{2'h0, 7'h70, 16'hffff}, '{2'h1, 7'h70, 16'h0003}, '{2'h0, 7'h01, 16'h0000},
		'{2'h0, 7'h5c, 16'h0001}, '{2'h0, 7'h01, 16'h0003}, '{2'h0, 7'h5c, 16'h0001},
		'{2'h2, 7'h00, 16'h0009}, '{2'h1, 7'h69, 16'h0018}, '{2'h1, 7'h55, 16'h0000},
		'{2'h1, 7'h5d, 16'h0000}, '{2'h0, 7'h01, 16'h0004}, '{2'h0, 7'h5c, 16'h0000},
		'{2'h2, 7'h00, 16'h0000}, '{2'h0, 7'h01, 16'h0002}, '{2'h0, 7'h5c, 16'h0001}
	};

	acr_regs #(.OTP_READY_CYCLES(20), .PART_ID(ID)) u_acr_regs (
		.core_clk(core_clk), .rst_b(rst_b), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
		.wr_data(wr_data), .rd_data(rd_data), .sync_pulse(sync_pulse),
		.conv_data(conv_data), .conv_in_range(conv_in_range),
		.otp_checksum_ok(otp_checksum_ok), .otp_cm_value(otp_cm_value),
		.otp_rin_value(otp_rin_value), .core_power_down(core_power_down),
		.full_swing(full_swing), .input_common_mode_code_use(input_common_mode_code_use), .rin_in_use(rin_in_use),
		.offset_from_spi(offset_from_spi), .out_data(out_data), .out_parity(out_parity),
		.out_in_range(out_in_range));
	acr_far_end u_acr_far_end (
		.core_clk(core_clk), .out_data(out_data), .conv_data(conv_data),
		.conv_in_range(conv_in_range), .otp_checksum_ok(otp_checksum_ok),
		.otp_cm_value(otp_cm_value), .otp_rin_value(otp_rin_value), .captured(cap));

	// ****************************************************************
	// clock, watchdog and shared tasks
	// ****************************************************************
	initial
	begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end
	// the longest stretch is the 4500-cycle checksum wait
	initial
	begin
		#(20000 * 5);
		fail_count++;
		end_sim();
	end
	task automatic end_sim;
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		num_checks++;
		if (got !== exp)
		begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic wr(input logic [6:0] a, input logic [15:0] d);
		@(posedge core_clk);
		#1 wr_en = 1'b1;
		addr = a;
		wr_data = d;
		@(posedge core_clk);
		#1 wr_en = 1'b0;
	endtask
	task automatic rd_chk(input logic [6:0] a, input logic [15:0] exp);
		@(posedge core_clk);
		#1 rd_en = 1'b1;
		addr = a;
		@(posedge core_clk);
		#1 rd_en = 1'b0;
		chk("rd_data", exp, rd_data);
	endtask
	// held several clocks so the pin synchroniser sees a clean edge
	task automatic pulse_sync;
		@(posedge core_clk);
		#1 sync_pulse = 1'b1;
		repeat (3) @(posedge core_clk);
		#1 sync_pulse = 1'b0;
		repeat (4) @(posedge core_clk);
		#1;
	endtask
	task automatic tick;
		@(posedge core_clk);
		#1;
	endtask

	// ****************************************************************
	// main sequence
	// ****************************************************************
	initial
	begin
		{rst_b, wr_en, rd_en, sync_pulse, addr, wr_data} = '0;
		repeat (10) @(posedge core_clk);
		#1 rst_b = 1'b1;
		foreach (rows[i])
		begin
			if (rows[i].op == 2'h0)
				wr(rows[i].a, rows[i].d);
			else if (rows[i].op == 2'h1)
				rd_chk(rows[i].a, rows[i].d);
			else
			begin
				repeat (2) tick();
				chk("core_power_down", rows[i].d, {12'h000, core_power_down});
			end
		end
		// reserved code with enable keeps normal samples
		wr(7'h01, 16'h0004);
		wr(7'h5c, 16'h0000);
		wr(7'h5d, 16'h0003);
		repeat (3) tick();
		chk("reserved", 16'h0123, {2'h0, out_data[13:0]});
		// ramp on all lanes, host syncs after enabling
		wr(7'h5d, 16'h0009);
		pulse_sync();
		repeat (8)
		begin
			tick();
			chk("ramp", {4'h0, cap[11:0] + 12'h001}, {4'h0, out_data[11:0]});
			chk("ramp_lane", {4'h0, out_data[11:0]}, {4'h0, out_data[53:42]});
		end
		// short flash: code 1 gives eight cycles
		wr(7'h69, 16'h0001);
		wr(7'h5d, 16'h000d);
		pulse_sync();
		n = 0;
		while (out_data[11:0] !== 12'hfff && n < 300)
		begin
			tick();
			n++;
		end
		n = 0;
		do
		begin
			tick();
			n++;
		end while (out_data[11:0] === 12'h000 && n < 300);
		chk("flash_len", 16'h0008, 16'(n));
		// sequence only, periods 1 and 2: one maximal cycle holds 64 ones
		wr(7'h5d, 16'h0000);
		wr(7'h55, 16'h0003);
		for (int p = 1; p <= 2; p++)
		begin
			if (p == 2)
				wr(7'h5e, 16'h0002);
			pulse_sync();
			ones = 0;
			repeat (127 * p)
			begin
				tick();
				b = out_data[0];
				ones += int'(b);
				chk("scr_lane", {4'h0, {12{b}}}, {2'h0, out_data[55:42]});
				chk("scr_par", {12'h000, {4{b}}}, {12'h000, out_parity});
				chk("scr_rng", {12'h000, {4{b}}}, {12'h000, out_in_range});
			end
			chk("scr_ones", 16'(64 * p), 16'(ones));
		end
		// a second sync restarts the sequence at the same point
		pulse_sync();
		for (int k = 0; k < 16; k++)
		begin
			s1[k] = out_data[0];
			tick();
		end
		pulse_sync();
		for (int k = 0; k < 16; k++)
		begin
			s2[k] = out_data[0];
			tick();
		end
		chk("scr_restart", s1, s2);
		// sequence plus signal: lane 0 is its sample flipped by the same sequence
		wr(7'h55, 16'h0001);
		pulse_sync();
		for (int k = 0; k < 16; k++)
		begin
			chk("scr_sig", {4'h0, 12'h123 ^ {12{s1[k]}}}, {4'h0, out_data[11:0]});
			tick();
		end
		// host checksum procedure
		wr(7'h55, 16'h0000);
		wr(7'h5d, 16'h0001);
		repeat (4500) @(posedge core_clk);
		wr(7'h01, 16'h0007);
		wr(7'h55, 16'h0003);
		wr(7'h16, 16'h0001);
		rd_chk(7'h05, 16'h00b1);
		chk("master_iso", 16'h0123, {2'h0, out_data[13:0]});
		chk("offset_src", 16'h0001, {15'h0000, offset_from_spi});
		chk("rin_src", 16'h0003, {12'h000, rin_in_use});
		chk("cm_src", 16'h000a, {11'h000, input_common_mode_code_use});
		// second reset: defaults and late fuse readiness
		rst_b = 1'b0;
		repeat (10) tick();
		rst_b = 1'b1;
		chk("pd_reset", 16'h0000, {12'h000, core_power_down});
		chk("swing_reset", 16'h0000, {15'h0000, full_swing});
		wr(7'h01, 16'h0000);
		rd_chk(7'h5a, 16'h0000);
		repeat (30) tick();
		rd_chk(7'h5a, 16'h0001);
		end_sim();
	end
endmodule
